// >>> verilog/zac_pkg.sv
/*
 * Shared constants and carrier types for the expansion card bus logic.
 * Assumes a single 50 MHz clock with the asynchronous bus sampled synchronously.
 */
`default_nettype none

package zac_pkg;

   // ==========================================================
   // Bus widths
   localparam int unsigned ADDR_HI_W = 24;
   localparam int unsigned ADDR_LO_W = 6;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned BASE_W    = 16;
   localparam int unsigned NYB_W     = 4;
   localparam int unsigned KEY_W     = 7;

   // ==========================================================
   // Configuration register byte offsets
   localparam logic [7:0] OFF_TYPE_SIZE  = 8'h00;
   localparam logic [7:0] OFF_PRODUCT    = 8'h04;
   localparam logic [7:0] OFF_MEM_FLAGS  = 8'h08;
   localparam logic [7:0] OFF_RSVD_ZERO  = 8'h0C;
   localparam logic [7:0] OFF_MAKER_HIGH = 8'h10;
   localparam logic [7:0] OFF_MAKER_LOW  = 8'h14;
   localparam logic [7:0] OFF_SERIAL_BLK = 8'h18;
   localparam logic [7:0] OFF_WO_FIRST   = 8'h40;
   localparam logic [7:0] OFF_BASE_WRITE = 8'h44;
   localparam logic [7:0] OFF_BASE_LOW   = 8'h48;
   localparam logic [7:0] OFF_SHUT_UP    = 8'h4C;

   // ==========================================================
   // Logical identity values
   localparam logic [7:0] TYPE_SIZE_VAL = 8'hA1;
   localparam logic [7:0] MEM_FLAGS_VAL = 8'hB1;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;

   // ==========================================================
   // Address decode and field positions
   localparam logic [7:0] CFG_SPACE_TOP = 8'hFF;
   localparam int unsigned A3_POS       = 1;
   localparam int unsigned NYB_TOP      = 31;
   localparam int unsigned NYB_BOT      = 28;
   localparam int unsigned BASE_TOP     = 31;
   localparam int unsigned BASE_BOT     = 16;
   localparam int unsigned MATCH_TOP    = 15;
   localparam int unsigned MATCH_BOT    = 9;

   // ==========================================================
   // Reset values
   localparam logic [BASE_W-1:0]    BASE_RST = 16'h0000;
   localparam logic [ADDR_HI_W-1:0] AHI_RST  = 24'h000000;
   localparam logic [NYB_W-1:0]     NYB_RST  = 4'hF;

   // Bus control strobes as sampled from the backplane.
   typedef struct packed {
      logic       fcs_n;
      logic       read;
      logic       ds_n;
      logic       doe;
      logic       berr_n;
      logic [2:0] fc;
   } zac_bus_ctl_t;

   typedef enum logic [2:0] {
      ZAC_UNCFG = 3'b001,
      ZAC_DONE  = 3'b010,
      ZAC_SHUT  = 3'b100
   } zac_state_t;

endpackage

`default_nettype wire

// >>> verilog/zac_id_rom.sv
/*
 * Identity nybble table: maps a physical nybble key to the top data nybble.
 * Assumes the caller qualifies the result with select and configuration state.
 */
`timescale 1ns/1ns
`default_nettype none

module zac_id_rom #(
   parameter logic [7:0]  PRODUCT_NUM = 8'h3C,
   parameter logic [15:0] MAKER_NUM   = 16'h1234
) (
   input  wire logic [zac_pkg::KEY_W-1:0] i_key,
   output var  logic [zac_pkg::NYB_W-1:0] o_nyb,
   output var  logic                      o_readable
);

   // ==========================================================
   // Logical byte lookup
   function automatic logic [7:0] zac_logical(input logic [5:0] idx);
      logic [7:0] v;
      v = zac_pkg::ZERO_BYTE;
      if (idx == zac_pkg::OFF_TYPE_SIZE[7:2]) begin
         v = zac_pkg::TYPE_SIZE_VAL;
      end else if (idx == zac_pkg::OFF_PRODUCT[7:2]) begin
         v = PRODUCT_NUM;
      end else if (idx == zac_pkg::OFF_MEM_FLAGS[7:2]) begin
         v = zac_pkg::MEM_FLAGS_VAL;
      end else if (idx == zac_pkg::OFF_MAKER_HIGH[7:2]) begin
         v = MAKER_NUM[15:8];
      end else if (idx == zac_pkg::OFF_MAKER_LOW[7:2]) begin
         v = MAKER_NUM[7:0];
      end
      return v;
   endfunction

   logic [7:0] phys_byte;

   always_comb begin
      phys_byte = zac_logical(i_key[6:1]);
      if (i_key[6:1] != zac_pkg::OFF_TYPE_SIZE[7:2]) begin
         phys_byte = ~phys_byte;
      end
      // Key bit zero carries A8, which selects the second nybble of the pair.
      o_nyb      = i_key[0] ? phys_byte[3:0] : phys_byte[7:4];
      o_readable = (i_key[6:1] < zac_pkg::OFF_WO_FIRST[7:2]);
   end

endmodule

`default_nettype wire

// >>> verilog/zac_card.sv
/*
 * Bus side of a slave-only 32-bit memory card: address latching, data buffer
 * control, identity nybbles and the write-only configuration registers.
 * Assumes bus inputs are already synchronous to i_sys_clk and held stable by
 * the host for at least two clocks per phase of a cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module zac_card #(
   parameter logic [7:0]  PRODUCT_NUM = 8'h3C,
   parameter logic [15:0] MAKER_NUM   = 16'h1234
) (
   input  wire logic                            i_sys_clk,
   input  wire logic                            i_rst_n,
   input  wire zac_pkg::zac_bus_ctl_t           i_bus_ctl,
   input  wire logic [31:8]                     i_addr_hi,
   input  wire logic [7:2]                      i_addr_lo,
   input  wire logic [zac_pkg::DATA_W-1:0]      i_data,
   input  wire logic                            i_cfgin_n,
   input  wire logic                            i_backplane_type_sense,
   output var  logic [31:8]                     o_addr_hi,
   output var  logic [7:2]                      o_addr_lo,
   output var  logic                            o_slave_n,
   output var  logic                            o_data_dir_out,
   output var  logic                            o_data_oe,
   output var  logic [zac_pkg::NYB_W-1:0]       o_id_nyb,
   output var  logic                            o_id_nyb_oe,
   output var  logic                            o_preconfig_flag,
   output var  logic                            o_base_latch_strobe,
   output var  logic [zac_pkg::BASE_W-1:0]      o_base_address_value,
   output var  logic                            o_cfgout_n,
   output var  logic                            o_configured,
   output var  logic                            o_shut_up
);

   // ==========================================================
   // Declarations
   logic [31:8]                addr_hi_r;
   logic [7:2]                 addr_lo_r;
   logic [31:8]                addr_view;
   logic                       fcs_prev_r;
   logic                       cycle_end;
   logic                       fc_ok;
   logic                       cfg_hit;
   logic                       run_hit;
   logic                       sel;
   logic [7:0]                 offset;
   logic                       wr_final;
   logic                       preconfig_r;
   logic                       base_latch_r;
   logic [zac_pkg::BASE_W-1:0] base_r;
   logic                       cfg_done_r;
   logic                       chain_hold_r;
   logic                       chain_hold_nxt;
   logic                       slave_n_r;
   logic                       dir_r;
   logic                       oe_r;
   logic [zac_pkg::NYB_W-1:0]  nyb_r;
   logic                       nyb_oe_r;
   logic                       cfgout_n_r;
   logic [zac_pkg::NYB_W-1:0]  rom_nyb;
   logic                       rom_readable;
   zac_pkg::zac_state_t        state_r;

   // ==========================================================
   // Decode helpers
   function automatic logic zac_fc_valid(input logic [2:0] fc);
      return fc[0] ^ fc[1];
   endfunction

   function automatic logic [7:0] zac_off(input logic [7:2] lo);
      return {lo, 2'b00};
   endfunction

   // ==========================================================
   // Address path
   // Transparent behaviour: the live bus value is used while the strobe is low,
   // so the comparator gains the full address setup time.
   assign addr_view = i_bus_ctl.fcs_n ? addr_hi_r : i_addr_hi;

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_hi_r <= zac_pkg::AHI_RST;
      end else if (!i_bus_ctl.fcs_n) begin
         addr_hi_r <= i_addr_hi;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_lo_r <= '0;
      end else begin
         addr_lo_r <= i_addr_lo;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fcs_prev_r <= 1'b1;
      end else begin
         fcs_prev_r <= i_bus_ctl.fcs_n;
      end
   end

   assign cycle_end = i_bus_ctl.fcs_n && !fcs_prev_r;

   // ==========================================================
   // Slave select
   assign fc_ok   = zac_fc_valid(i_bus_ctl.fc);
   assign cfg_hit = !cfg_done_r && (addr_view[31:24] == zac_pkg::CFG_SPACE_TOP);
   assign run_hit = base_latch_r && cfg_done_r
                    && (addr_view[31:25] == base_r[zac_pkg::MATCH_TOP:zac_pkg::MATCH_BOT]);
   assign sel     = !i_bus_ctl.fcs_n && fc_ok && (cfg_hit || run_hit);
   assign offset  = zac_off(i_addr_lo);

   // Only 44 and 4C end configuration; 40, 48 and the rest are ignored.
   assign wr_final = sel && cfg_hit && !i_bus_ctl.read && !i_bus_ctl.ds_n
                     && ((offset == zac_pkg::OFF_BASE_WRITE) || (offset == zac_pkg::OFF_SHUT_UP));

   // ==========================================================
   // Configuration state
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         preconfig_r <= 1'b0;
      end else if (wr_final) begin
         preconfig_r <= 1'b1;
      end
   end

   // The strobe sets while the write data is still valid, so the base is
   // captured from the very same write that raised the flag.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         base_latch_r <= 1'b0;
         base_r       <= zac_pkg::BASE_RST;
      end else if (!base_latch_r && sel && preconfig_r && !i_addr_lo[zac_pkg::A3_POS + 2]
                   && !i_bus_ctl.ds_n && !i_bus_ctl.read) begin
         base_latch_r <= 1'b1;
         base_r       <= i_data[zac_pkg::BASE_TOP:zac_pkg::BASE_BOT];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_done_r <= 1'b0;
      end else if (cycle_end && preconfig_r) begin
         cfg_done_r <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= zac_pkg::ZAC_UNCFG;
      end else begin
         unique case (state_r)
            zac_pkg::ZAC_UNCFG: begin
               if (cycle_end && preconfig_r) begin
                  state_r <= base_latch_r ? zac_pkg::ZAC_DONE : zac_pkg::ZAC_SHUT;
               end
            end
            zac_pkg::ZAC_DONE: begin
               state_r <= zac_pkg::ZAC_DONE;
            end
            zac_pkg::ZAC_SHUT: begin
               state_r <= zac_pkg::ZAC_SHUT;
            end
            default: begin
               state_r <= zac_pkg::ZAC_UNCFG;
            end
         endcase
      end
   end

   // ==========================================================
   // Chain-out
   always_comb begin
      chain_hold_nxt = chain_hold_r && preconfig_r;
      if (cycle_end && preconfig_r && !i_cfgin_n) begin
         chain_hold_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         chain_hold_r <= 1'b0;
         cfgout_n_r   <= 1'b1;
      end else begin
         chain_hold_r <= chain_hold_nxt;
         // An older backplane cannot configure this card, so it steps aside.
         cfgout_n_r   <= !(chain_hold_nxt || (!i_cfgin_n && !i_backplane_type_sense));
      end
   end

   // ==========================================================
   // Data buffers and identity nybbles
   zac_id_rom #(
      .PRODUCT_NUM (PRODUCT_NUM),
      .MAKER_NUM   (MAKER_NUM)
   ) u_rom (
      .i_key      ({i_addr_lo, addr_view[8]}),
      .o_nyb      (rom_nyb),
      .o_readable (rom_readable)
   );

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slave_n_r <= 1'b1;
         dir_r     <= 1'b0;
         oe_r      <= 1'b0;
      end else begin
         slave_n_r <= !sel;
         dir_r     <= sel && i_bus_ctl.read;
         oe_r      <= sel && i_bus_ctl.doe && i_bus_ctl.berr_n;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         nyb_r    <= zac_pkg::NYB_RST;
         nyb_oe_r <= 1'b0;
      end else begin
         nyb_r    <= rom_nyb;
         nyb_oe_r <= sel && cfg_hit && !preconfig_r && i_bus_ctl.read && rom_readable;
      end
   end

   // ==========================================================
   // Outputs
   assign o_addr_hi            = addr_hi_r;
   assign o_addr_lo            = addr_lo_r;
   assign o_slave_n            = slave_n_r;
   assign o_data_dir_out       = dir_r;
   assign o_data_oe            = oe_r;
   assign o_id_nyb             = nyb_r;
   assign o_id_nyb_oe          = nyb_oe_r;
   assign o_preconfig_flag     = preconfig_r;
   assign o_base_latch_strobe  = base_latch_r;
   assign o_base_address_value = base_r;
   assign o_cfgout_n           = cfgout_n_r;
   assign o_configured         = state_r == zac_pkg::ZAC_DONE;
   assign o_shut_up            = state_r == zac_pkg::ZAC_SHUT;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   addr_hold_a: assert property (i_bus_ctl.fcs_n |=> $stable(o_addr_hi))
      else $error("Latched address moved while strobe negated.");

   addr_low_pass_a: assert property (1'b1 |=> (o_addr_lo == $past(i_addr_lo)))
      else $error("Low address not buffered through.");

   dir_read_a: assert property (o_data_dir_out |-> (!o_slave_n && $past(i_bus_ctl.read)))
      else $error("Data buffer pointed out without a selected read.");

   oe_qual_a: assert property (o_data_oe |-> ($past(i_bus_ctl.doe) && $past(i_bus_ctl.berr_n) && !o_slave_n))
      else $error("Data buffer enabled without select, doe or with error.");

   nyb_gate_a: assert property (o_id_nyb_oe |-> (!o_preconfig_flag && o_data_dir_out))
      else $error("Identity nybble driven after configuration or off a read.");

   nyb_zero_reg_a: assert property ((sel && i_bus_ctl.read && offset == zac_pkg::OFF_TYPE_SIZE && !addr_view[8])
                                    |=> (o_id_nyb == 4'hA))
      else $error("Register zero first nybble wrong.");

   nyb_flags_a: assert property ((sel && offset == zac_pkg::OFF_MEM_FLAGS && addr_view[8])
                                 |=> (o_id_nyb == 4'hE))
      else $error("Register eight second nybble wrong.");

   nyb_zero_inv_a: assert property ((sel && offset == zac_pkg::OFF_RSVD_ZERO) |=> (o_id_nyb == 4'hF))
      else $error("Reserved register did not read as inverted zero.");

   flag_set_a: assert property (wr_final |=> o_preconfig_flag)
      else $error("Pre-configuration flag missed the final write.");

   flag_sticky_a: assert property (o_preconfig_flag |=> o_preconfig_flag [*2])
      else $error("Pre-configuration flag dropped before reset.");

   base_take_a: assert property ($rose(o_base_latch_strobe)
                                 |-> (o_base_address_value == $past(i_data[31:16])))
      else $error("Base address not taken from the strobe write.");

   strobe_cause_a: assert property ($rose(o_base_latch_strobe) |-> $past(preconfig_r))
      else $error("Base strobe rose without the flag.");

   old_backplane_a: assert property ((!i_cfgin_n && !i_backplane_type_sense) |=> !o_cfgout_n)
      else $error("Chain-out not asserted on an older backplane.");

   chain_end_a: assert property ((cycle_end && preconfig_r && !i_cfgin_n) |=> !o_cfgout_n [*2])
      else $error("Chain-out not asserted and held at cycle end.");

   shut_no_base_a: assert property (o_shut_up |-> !o_base_latch_strobe)
      else $error("Shut-up card holds a base address.");

   cfg_space_a: assert property ((!o_slave_n && !o_configured) |-> ($past(addr_view[31:24]) == 8'hFF))
      else $error("Unconfigured card selected outside configuration space.");

   rom_read_c: cover property (o_id_nyb_oe ##1 !o_id_nyb_oe);
   base_write_c: cover property ($rose(o_base_latch_strobe) ##[1:20] o_configured);
   shut_write_c: cover property ($rose(o_preconfig_flag) ##[1:20] o_shut_up);
   chain_out_c: cover property ($fell(o_cfgout_n));

endmodule

`default_nettype wire

// >>> tb/zac_host_model.sv
/*
 * Host model of the expansion bus: drives read and write cycles into the card.
 * Assumes one caller at a time and the 50 MHz bench clock.
 */
`timescale 1ns/1ns
`default_nettype none

module zac_host_model (
   input  wire logic                  i_sys_clk,
   output var  zac_pkg::zac_bus_ctl_t o_bus_ctl,
   output var  logic [31:8]           o_addr_hi,
   output var  logic [7:2]            o_addr_lo,
   output var  logic [31:0]           o_data
);
   // ==========================================================
   // Bus phases
   initial begin
      o_bus_ctl = 8'hE8;
      o_addr_hi = '0;
      o_addr_lo = '0;
      o_data    = '0;
   end

   // Holds each cycle for three edges, above the card's two-clock minimum.
   task automatic cycle(input logic rd, input logic [31:0] adr, input logic [31:0] dat = '0,
                        input logic [2:0] fc = 3'b001, input logic doe = 1'b1, input logic berr_n = 1'b1);
      @(posedge i_sys_clk);
      #2;
      {o_addr_hi, o_addr_lo} = adr[31:2];
      o_data = dat;
      o_bus_ctl = {1'b0, rd, 1'b0, doe, berr_n, fc};
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask

   // Released lines flip to the inverse of their last value, so stale sampling shows.
   task automatic idle();
      @(posedge i_sys_clk);
      #2;
      o_bus_ctl = 8'hE8;
      o_addr_hi = ~o_addr_hi;
      o_addr_lo = ~o_addr_lo;
      o_data    = ~o_data;
      repeat (3) @(posedge i_sys_clk);
      #1;
   endtask
endmodule

`default_nettype wire

// >>> tb/zac_card_tb.sv
/*
 * Self-checking bench for the card: identity reads, select and buffer control,
 * base address and shut-up writes, chain-out.
 * Assumes the host model in tb/ and the package and design under verilog/.
 */
`timescale 1ns/1ns
`default_nettype none

module zac_card_tb;
   localparam logic [7:0]  PROD  = 8'h5A;    // Arbitrary identity value.
   localparam logic [15:0] MAKER = 16'hC3E7; // Arbitrary identity value.

   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  cfgin_n = 1'b1;
   logic                  sense = 1'b1;
   zac_pkg::zac_bus_ctl_t bus_ctl;
   logic [31:8]           a_hi, o_a_hi;
   logic [7:2]            a_lo, o_a_lo;
   logic [31:0]           data;
   logic                  slave_n, dir, doe, nyb_oe, pre, strobe, cfgout_n, cfgd, shut;
   logic [3:0]            nyb;
   logic [15:0]           base;
   int                    fails = 0;
   int                    compares = 0;
   int                    cycles = 0;

   // ==========================================================
   // Clock, timeout and instances
   always #10 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         $display("Error at %0t: timeout", $time);
         summarize();
      end
   end

   zac_host_model u_zac_host_model (.i_sys_clk(clk), .o_bus_ctl(bus_ctl), .o_addr_hi(a_hi),
                                    .o_addr_lo(a_lo), .o_data(data));

   zac_card #(.PRODUCT_NUM(PROD), .MAKER_NUM(MAKER)) u_zac_card (
      .i_sys_clk(clk), .i_rst_n(rst_n), .i_bus_ctl(bus_ctl), .i_addr_hi(a_hi), .i_addr_lo(a_lo),
      .i_data(data), .i_cfgin_n(cfgin_n), .i_backplane_type_sense(sense), .o_addr_hi(o_a_hi),
      .o_addr_lo(o_a_lo), .o_slave_n(slave_n), .o_data_dir_out(dir), .o_data_oe(doe),
      .o_id_nyb(nyb), .o_id_nyb_oe(nyb_oe), .o_preconfig_flag(pre), .o_base_latch_strobe(strobe),
      .o_base_address_value(base), .o_cfgout_n(cfgout_n), .o_configured(cfgd), .o_shut_up(shut));

   // ==========================================================
   // Helpers
   task automatic summarize();
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      #2 rst_n = 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // Checks select, direction, buffer enable and nybble enable as one vector.
   task automatic probe(input logic [31:0] adr, input logic [2:0] fc, input logic oe_in,
                        input logic berr_n, input logic [3:0] exp);
      u_zac_host_model.cycle(1'b1, adr, 32'h0, fc, oe_in, berr_n);
      chk({slave_n, dir, doe, nyb_oe}, exp, "select");
      u_zac_host_model.idle();
   endtask

   // Physical nybble worked out from the logical identity bytes.
   function automatic logic [3:0] exp_nyb(input logic [7:0] r, input logic s);
      logic [7:0] b;
      case (r)
         8'h00: b = 8'hA1;
         8'h04: b = PROD;
         8'h08: b = 8'hB1;
         8'h10: b = MAKER[15:8];
         8'h14: b = MAKER[7:0];
         default: b = 8'h00;
      endcase
      if (r != 8'h00) b = ~b;
      return s ? b[3:0] : b[7:4];
   endfunction

   // ==========================================================
   // Main sequence
   initial begin
      do_reset();
      chk({slave_n, nyb_oe, pre, cfgout_n}, 4'b1001, "reset state");
      for (int r = 0; r < 64; r += 4) begin
         for (int s = 0; s < 2; s++) begin
            u_zac_host_model.cycle(1'b1, {8'hFF, 15'h1357, s[0], r[7:0]});
            chk({slave_n, dir, doe, nyb_oe}, 4'b0111, "id select");
            chk(nyb, exp_nyb(r[7:0], s[0]), "id nybble");
            u_zac_host_model.idle();
         end
      end
      probe(32'hFF000040, 3'b001, 1'b1, 1'b1, 4'b0110);
      probe(32'hFF00017C, 3'b010, 1'b1, 1'b1, 4'b0110);
      probe(32'hFF000000, 3'b001, 1'b0, 1'b1, 4'b0101);
      probe(32'hFF000000, 3'b001, 1'b1, 1'b0, 4'b0101);
      probe(32'hFF000000, 3'b000, 1'b1, 1'b1, 4'b1000);
      probe(32'hFF000000, 3'b011, 1'b1, 1'b1, 4'b1000);
      probe(32'hFE000000, 3'b001, 1'b1, 1'b1, 4'b1000);
      u_zac_host_model.cycle(1'b1, 32'hFF2468A0);
      chk({o_a_hi, o_a_lo}, {24'hFF2468, 6'h28}, "address pass");
      u_zac_host_model.idle();
      chk({o_a_hi, o_a_lo}, {24'hFF2468, 6'h17}, "address hold");
      u_zac_host_model.cycle(1'b0, 32'hFF000048, 32'h9ABC0000);
      chk({slave_n, dir}, 2'b00, "write direction");
      u_zac_host_model.idle();
      u_zac_host_model.cycle(1'b0, 32'hFF000040, 32'h9ABC0000);
      u_zac_host_model.idle();
      chk({pre, strobe, cfgd, shut}, 4'b0000, "ignored writes");
      cfgin_n = 1'b0;
      u_zac_host_model.cycle(1'b0, 32'hFF000044, 32'hB6C05555);
      chk({pre, cfgout_n}, 2'b11, "preconfig on base write");
      u_zac_host_model.idle();
      chk({strobe, base}, {1'b1, 16'hB6C0}, "base latch");
      chk({cfgd, shut, cfgout_n}, 3'b100, "configured");
      probe(32'hFF000000, 3'b001, 1'b1, 1'b1, 4'b1000);
      probe(32'hB7123400, 3'b001, 1'b1, 1'b1, 4'b0110);
      cfgin_n = 1'b1;
      do_reset();
      chk({pre, strobe, base}, 18'h0, "cleared by reset");
      // Chain-in stands before the final write, as the chain order demands.
      cfgin_n = 1'b0;
      u_zac_host_model.cycle(1'b0, 32'hFF00004C, 32'h12345678);
      chk({pre, cfgout_n}, 2'b11, "preconfig on shut-up");
      u_zac_host_model.idle();
      chk({shut, strobe, cfgout_n}, 3'b100, "shut up");
      repeat (2) @(posedge clk);
      #1;
      chk(cfgout_n, 1'b0, "chain-out held");
      probe(32'hFF000000, 3'b001, 1'b1, 1'b1, 4'b1000);
      cfgin_n = 1'b1;
      sense = 1'b0;
      do_reset();
      chk(cfgout_n, 1'b1, "chain-out idle");
      @(posedge clk);
      #2 cfgin_n = 1'b0;
      @(posedge clk);
      #1;
      chk(cfgout_n, 1'b0, "older backplane");
      summarize();
   end
endmodule

`default_nettype wire
